// >>> src/vlft_pkg.sv
// Constants for the video line and field trigger selector.
// Assumes a 50 MHz pclk and a 32-bit APB register bus.
`default_nettype none
package vlft_pkg;
  // ****************************************
  // Clock and line timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 20;
  // Horizontal line period, 63.5 us written in ns
  localparam int H_PERIOD_NS = 63500;
  localparam int H_PERIOD_CYC = H_PERIOD_NS / CLK_PERIOD_NS;
  // Field start later than three quarters of a line after line sync is field one
  localparam logic [11:0] FIELD_ONE_THRESH = 12'((H_PERIOD_CYC * 3) / 4);
  localparam logic [11:0] HCNT_MAX = 12'hfff;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_LINE = 8'h04;
  localparam logic [7:0] ADDR_KNOB = 8'h08;
  localparam logic [7:0] ADDR_BLEVEL = 8'h0c;
  localparam logic [7:0] ADDR_MAIN_DLY = 8'h10;
  localparam logic [7:0] ADDR_DELTA_DLY = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;

  // CTRL field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_SYS_M_BIT = 2;
  localparam int CTRL_STD625_BIT = 3;
  localparam int CTRL_CLAMP_BIT = 4;
  localparam int CTRL_BSEL_BIT = 5;
  localparam int CTRL_DLYSWP_BIT = 6;
  localparam int CTRL_DELTA_BIT = 7;
  // KNOB write bits
  localparam int KNOB_CW_BIT = 0;
  localparam int KNOB_CCW_BIT = 1;

  // Field trigger modes
  localparam logic [1:0] MODE_FIELD1 = 2'h0;
  localparam logic [1:0] MODE_FIELD2 = 2'h1;
  localparam logic [1:0] MODE_ALT = 2'h2;
  localparam logic [1:0] MODE_ANY = 2'h3;

  // ****************************************
  // Line numbering limits and start values
  // ****************************************
  localparam logic [9:0] LINE_ONE = 10'h001;
  localparam logic [9:0] MAX1_525 = 10'd263;
  localparam logic [9:0] MAX2_525 = 10'd262;
  localparam logic [9:0] ALTMAX_525 = 10'd262;
  localparam logic [9:0] MAX1_625 = 10'd313;
  localparam logic [9:0] MIN2_625 = 10'd313;
  localparam logic [9:0] MAX2_625 = 10'd625;
  localparam logic [9:0] ALTMAX_625 = 10'd312;
  // Offset of field two lines in 625 alternate mode
  localparam logic [9:0] F2_OFS_625 = 10'd312;
  // Lines counted ahead of field sync under system M
  localparam logic [9:0] SYS_M_LEAD = 10'd3;

  // Reset values
  localparam logic [1:0] RST_MODE = MODE_FIELD1;
  localparam logic [9:0] RST_LINE = LINE_ONE;
  localparam logic [9:0] RST_BLEVEL = 10'h200;
  localparam logic [15:0] RST_DLY = 16'h0000;
endpackage
`default_nettype wire

// >>> src/vlft_top.sv
// Video line and field trigger selector with APB register access.
// Assumes sync pulses from an external sync separator (asynchronous pins)
// and a holdoff-done level from trigger logic on pclk.
//
// Functional notes
// - Alternate mode triggers each field in turn
// - Any-line fires on every line sync not coincident with a field sync, while holdoff done
// - Single field wraps into opposite field; field one wraps to itself when not interlaced
// - Alternate mode wraps between one and common max
// - Clockwise raises line, counterclockwise lowers
// - Second trigger selected: knob sets its level
// - System M counts three lines early
// - 525 field one: full-line equalizer, 263 lines
// - 525 field two: half-line equalizer, 262 lines
// - 625 continuous numbering, field two 313-625
// - No burst decode; fields 1/3, 2/4
// - Non-interlaced: field start only, no parity
// - Delayed alternate: second field adds delta
// - Field selected shows field/line readout
// - Clamp active with message until off
// - Field two only when interlaced
`default_nettype none
module vlft_top
  import vlft_pkg::*;
(
  // APB clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Sync separator pins
  input wire logic line_sync,
  input wire logic field_sync,
  // Trigger system
  input wire logic holdoff_done,
  output logic trig_fire,
  output logic [15:0] sweep_delay,
  // Indicators and clamp
  output logic first_field_indicator,
  output logic second_field_indicator,
  output logic alternate_field_indicator,
  output logic any_line_indicator,
  output logic line_readout_show,
  output logic level_readout_show,
  output logic clamp_ch2_en,
  output logic clamp_msg
);

  // ****************************************
  // Declarations
  // ****************************************
  logic [1:0] mode_reg;
  logic sys_m_reg;
  logic std625_reg;
  logic clamp_reg;
  logic bsel_reg;
  logic dlyswp_reg;
  logic delta_reg;
  logic [9:0] line_reg;
  logic [9:0] blevel_reg;
  logic [15:0] main_dly_reg;
  logic [15:0] delta_dly_reg;
  logic [1:0] ls_sync_reg;
  logic [1:0] fs_sync_reg;
  logic ls_prev_reg;
  logic fs_prev_reg;
  logic [11:0] hcnt_reg;
  logic field_one_reg;
  logic last_parity_reg;
  logic interlaced_reg;
  logic [9:0] lcnt_reg;
  logic alt_want_one_reg;
  logic fired_two_reg;
  logic trig_reg;
  logic [31:0] rdata_reg;
  logic ls_edge;
  logic fs_edge;
  logic parity_now;
  logic wr_en;
  logic rd_en;
  logic knob_cw;
  logic knob_ccw;
  logic [9:0] max1;
  logic [9:0] min2;
  logic [9:0] max2;
  logic [9:0] altmax;
  logic [9:0] next_line;
  logic [9:0] target;
  logic field_ok;
  logic [1:0] mode_next;
  logic [9:0] line_next;
  logic [9:0] start_val;
  logic addr_ok;

  // ****************************************
  // APB decode
  // ****************************************
  // Zero wait state slave
  assign pready = 1'b1;
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & ~penable & ~pwrite;
  assign addr_ok = (paddr == ADDR_CTRL) || (paddr == ADDR_LINE) || (paddr == ADDR_KNOB) ||
                   (paddr == ADDR_BLEVEL) || (paddr == ADDR_MAIN_DLY) ||
                   (paddr == ADDR_DELTA_DLY) || (paddr == ADDR_STATUS);
  assign pslverr = psel & penable & ~addr_ok;
  assign knob_cw = wr_en && (paddr == ADDR_KNOB) && pwdata[KNOB_CW_BIT] &&
                   !pwdata[KNOB_CCW_BIT];
  assign knob_ccw = wr_en && (paddr == ADDR_KNOB) && pwdata[KNOB_CCW_BIT] &&
                    !pwdata[KNOB_CW_BIT];

  // ****************************************
  // Line limits per standard
  // ****************************************
  // 625 or 525 limits, chosen by std625_reg
  always_comb begin
    if (std625_reg) begin
      max1 = MAX1_625;
      min2 = MIN2_625;
      max2 = MAX2_625;
      altmax = ALTMAX_625;
    end else begin
      max1 = MAX1_525;
      min2 = LINE_ONE;
      max2 = MAX2_525;
      altmax = ALTMAX_525;
    end
  end

  // ****************************************
  // Control register
  // ****************************************
  // Mode written by software, field two refused unless interlaced
  always_comb begin
    mode_next = mode_reg;
    if (wr_en && paddr == ADDR_CTRL) begin
      if (pwdata[CTRL_MODE_LSB +: 2] != MODE_FIELD2 || interlaced_reg) begin
        mode_next = pwdata[CTRL_MODE_LSB +: 2];
      end
    end else if (knob_cw && !bsel_reg) begin
      if (mode_reg == MODE_FIELD1 && line_reg == max1 && interlaced_reg) begin
        mode_next = MODE_FIELD2;
      end else if (mode_reg == MODE_FIELD2 && line_reg == max2) begin
        mode_next = MODE_FIELD1;
      end
    end else if (knob_ccw && !bsel_reg) begin
      if (mode_reg == MODE_FIELD1 && line_reg == LINE_ONE && interlaced_reg) begin
        mode_next = MODE_FIELD2;
      end else if (mode_reg == MODE_FIELD2 && line_reg == min2) begin
        mode_next = MODE_FIELD1;
      end
    end
  end

  // Control bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= RST_MODE;
      sys_m_reg <= 1'b1;
      std625_reg <= 1'b0;
      clamp_reg <= 1'b0;
      bsel_reg <= 1'b0;
      dlyswp_reg <= 1'b0;
      delta_reg <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      if (wr_en && paddr == ADDR_CTRL) begin
        sys_m_reg <= pwdata[CTRL_SYS_M_BIT];
        std625_reg <= pwdata[CTRL_STD625_BIT];
        clamp_reg <= pwdata[CTRL_CLAMP_BIT];
        bsel_reg <= pwdata[CTRL_BSEL_BIT];
        dlyswp_reg <= pwdata[CTRL_DLYSWP_BIT];
        delta_reg <= pwdata[CTRL_DELTA_BIT];
      end
    end
  end

  // ****************************************
  // Line setting stepping
  // ****************************************
  always_comb begin
    line_next = line_reg;
    if (wr_en && paddr == ADDR_LINE) begin
      line_next = pwdata[9:0];
    end else if (knob_cw && !bsel_reg) begin
      unique case (mode_reg)
        MODE_FIELD1: begin
          // wrap to start of field two, or to line one when not interlaced
          if (line_reg == max1) begin
            line_next = interlaced_reg ? min2 : LINE_ONE;
          end else begin
            line_next = line_reg + 10'h001;
          end
        end
        MODE_FIELD2: begin
          line_next = (line_reg == max2) ? LINE_ONE : line_reg + 10'h001;
        end
        MODE_ALT: begin
          line_next = (line_reg >= altmax) ? LINE_ONE : line_reg + 10'h001;
        end
        MODE_ANY: begin
          line_next = line_reg;
        end
      endcase
    end else if (knob_ccw && !bsel_reg) begin
      unique case (mode_reg)
        MODE_FIELD1: begin
          // wrap to end of field two, or of field one when not interlaced
          if (line_reg == LINE_ONE) begin
            line_next = interlaced_reg ? max2 : max1;
          end else begin
            line_next = line_reg - 10'h001;
          end
        end
        MODE_FIELD2: begin
          line_next = (line_reg == min2) ? max1 : line_reg - 10'h001;
        end
        MODE_ALT: begin
          line_next = (line_reg <= LINE_ONE) ? altmax : line_reg - 10'h001;
        end
        MODE_ANY: begin
          line_next = line_reg;
        end
      endcase
    end
  end

  // Line setting and second trigger level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_reg <= RST_LINE;
      blevel_reg <= RST_BLEVEL;
    end else begin
      line_reg <= line_next;
      if (wr_en && paddr == ADDR_BLEVEL) begin
        blevel_reg <= pwdata[9:0];
      end else if (knob_cw && bsel_reg) begin
        blevel_reg <= blevel_reg + 10'h001;
      end else if (knob_ccw && bsel_reg) begin
        blevel_reg <= blevel_reg - 10'h001;
      end
    end
  end

  // Delay settings
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      main_dly_reg <= RST_DLY;
      delta_dly_reg <= RST_DLY;
    end else begin
      if (wr_en && paddr == ADDR_MAIN_DLY) begin
        main_dly_reg <= pwdata[15:0];
      end
      if (wr_en && paddr == ADDR_DELTA_DLY) begin
        delta_dly_reg <= pwdata[15:0];
      end
    end
  end

  // ****************************************
  // Sync input capture
  // ****************************************
  // Two-stage synchronisers, then edge detect on the second stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ls_sync_reg <= 2'b00;
      fs_sync_reg <= 2'b00;
      ls_prev_reg <= 1'b0;
      fs_prev_reg <= 1'b0;
    end else begin
      ls_sync_reg <= {ls_sync_reg[0], line_sync};
      fs_sync_reg <= {fs_sync_reg[0], field_sync};
      ls_prev_reg <= ls_sync_reg[1];
      fs_prev_reg <= fs_sync_reg[1];
    end
  end
  assign ls_edge = ls_sync_reg[1] & ~ls_prev_reg;
  assign fs_edge = fs_sync_reg[1] & ~fs_prev_reg;

  // ****************************************
  // Field identification
  // ****************************************
  // full line gap marks field one
  assign parity_now = (hcnt_reg >= FIELD_ONE_THRESH);

  // Cycles since last line sync, saturating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hcnt_reg <= 12'h000;
    end else if (ls_edge) begin
      hcnt_reg <= 12'h000;
    end else if (hcnt_reg != HCNT_MAX) begin
      hcnt_reg <= hcnt_reg + 12'h001;
    end
  end

  // Parity and interlace state, updated at each field start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      field_one_reg <= 1'b1;
      last_parity_reg <= 1'b1;
      interlaced_reg <= 1'b0;
    end else if (fs_edge) begin
      last_parity_reg <= parity_now;
      interlaced_reg <= (parity_now != last_parity_reg);
      // only two-field parity, no burst phase
      field_one_reg <= (parity_now != last_parity_reg) ? parity_now : 1'b1;
    end
  end

  // ****************************************
  // Line counter
  // ****************************************
  // system M starts three lines early
  // 625 field two reloads at 313
  always_comb begin
    start_val = (std625_reg && interlaced_reg && !parity_now) ? MIN2_625 : LINE_ONE;
    if (sys_m_reg) begin
      start_val = start_val + SYS_M_LEAD;
    end
  end

  // count lines, reload at field sync
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lcnt_reg <= LINE_ONE;
    end else if (fs_edge) begin
      lcnt_reg <= start_val;
    end else if (ls_edge) begin
      lcnt_reg <= lcnt_reg + 10'h001;
    end
  end
  assign next_line = lcnt_reg + 10'h001;

  // ****************************************
  // Trigger selection
  // ****************************************
  // Target line and field match for the current field
  always_comb begin
    target = line_reg;
    field_ok = 1'b0;
    unique case (mode_reg)
      MODE_FIELD1: begin
        field_ok = field_one_reg;
      end
      MODE_FIELD2: begin
        field_ok = !field_one_reg && interlaced_reg;
      end
      MODE_ALT: begin
        field_ok = (field_one_reg == alt_want_one_reg) || !interlaced_reg;
        if (std625_reg && !field_one_reg) begin
          target = line_reg + F2_OFS_625;
        end
      end
      MODE_ANY: begin
        field_ok = 1'b1;
      end
    endcase
  end

  // Trigger pulse and alternate bookkeeping
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_reg <= 1'b0;
      alt_want_one_reg <= 1'b1;
      fired_two_reg <= 1'b0;
    end else begin
      trig_reg <= 1'b0;
      if (ls_edge && !fs_edge && holdoff_done && field_ok) begin
        // any line fires on every line sync not coincident with a field sync, while holdoff done
        if (mode_reg == MODE_ANY) begin
          trig_reg <= 1'b1;
        end else if (next_line == target) begin
          trig_reg <= 1'b1;
          fired_two_reg <= !field_one_reg;
          if (mode_reg == MODE_ALT) begin
            alt_want_one_reg <= !field_one_reg;
          end
        end
      end
    end
  end
  assign trig_fire = trig_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sweep_delay <= RST_DLY;
    end else if (mode_reg == MODE_ALT && dlyswp_reg && delta_reg && fired_two_reg) begin
      sweep_delay <= main_dly_reg + delta_dly_reg;
    end else begin
      sweep_delay <= main_dly_reg;
    end
  end

  // ****************************************
  // Indicators and clamp
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_field_indicator <= 1'b0;
      second_field_indicator <= 1'b0;
      alternate_field_indicator <= 1'b0;
      any_line_indicator <= 1'b0;
      line_readout_show <= 1'b0;
      level_readout_show <= 1'b1;
      clamp_ch2_en <= 1'b0;
      clamp_msg <= 1'b0;
    end else begin
      first_field_indicator <= (mode_reg == MODE_FIELD1);
      second_field_indicator <= (mode_reg == MODE_FIELD2);
      alternate_field_indicator <= (mode_reg == MODE_ALT);
      any_line_indicator <= (mode_reg == MODE_ANY);
      line_readout_show <= (mode_reg != MODE_ANY);
      level_readout_show <= (mode_reg == MODE_ANY);
      clamp_ch2_en <= clamp_reg;
      clamp_msg <= clamp_reg;
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  // Captured in the setup phase, shown during access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_reg <= 32'h0000_0000;
    end else if (rd_en) begin
      unique case (paddr)
        ADDR_CTRL: begin
          rdata_reg <= {24'h00_0000, delta_reg, dlyswp_reg, bsel_reg, clamp_reg,
                        std625_reg, sys_m_reg, mode_reg};
        end
        ADDR_LINE: rdata_reg <= {22'h00_0000, line_reg};
        ADDR_BLEVEL: rdata_reg <= {22'h00_0000, blevel_reg};
        ADDR_MAIN_DLY: rdata_reg <= {16'h0000, main_dly_reg};
        ADDR_DELTA_DLY: rdata_reg <= {16'h0000, delta_dly_reg};
        ADDR_STATUS: begin
          rdata_reg <= {16'h0000, 3'h0, interlaced_reg, field_one_reg, clamp_reg,
                        lcnt_reg};
        end
        default: rdata_reg <= 32'h0000_0000;
      endcase
    end
  end
  assign prdata = rdata_reg;

endmodule // vlft_top
`default_nettype wire

// >>> dv/vlft_checker_assertions.sv
// Port checker for the video line and field trigger selector.
// Assumes it is bound onto vlft_top and runs in the single pclk domain.
`default_nettype none
module vlft_checker (
  // Clock, reset and APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic pslverr,
  // Sync and trigger
  input wire logic line_sync,
  input wire logic holdoff_done,
  input wire logic trig_fire,
  // Indicators and clamp
  input wire logic first_field_indicator,
  input wire logic second_field_indicator,
  input wire logic alternate_field_indicator,
  input wire logic any_line_indicator,
  input wire logic line_readout_show,
  input wire logic level_readout_show,
  input wire logic clamp_ch2_en,
  input wire logic clamp_msg
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ****************************************
  // Sequences
  // ****************************************
  sequence s_apb_access;
    psel && penable;
  endsequence
  sequence s_holdoff_low;
    !holdoff_done;
  endsequence
  // ****************************************
  // Assertions
  // ****************************************
  a_fire_one_cycle: assert property (trig_fire |=> !trig_fire)
    else $error("trigger pulse longer than one cycle");
  a_fire_after_line: assert property (trig_fire |-> ($past(line_sync, 2) ||
    $past(line_sync, 3) || $past(line_sync, 4) || $past(line_sync, 5)))
    else $error("trigger without a recent line sync");
  a_holdoff_gates_fire: assert property (s_holdoff_low |=> !trig_fire)
    else $error("trigger while holdoff not done");
  a_mode_indicator_onehot: assert property ($onehot0({first_field_indicator,
    second_field_indicator, alternate_field_indicator, any_line_indicator}))
    else $error("more than one mode indicator");
  a_readout_follows_mode: assert property (line_readout_show == (first_field_indicator
    || second_field_indicator || alternate_field_indicator))
    else $error("line readout does not match field mode");
  a_readout_pair: assert property (level_readout_show != line_readout_show)
    else $error("level and line readouts not exclusive");
  a_any_line_hidden: assert property (any_line_indicator |-> !line_readout_show)
    else $error("line readout shown in any-line mode");
  a_clamp_msg_pair: assert property (clamp_ch2_en == clamp_msg)
    else $error("clamp message differs from clamp");
  a_indicator_needs_write: assert property ($changed({first_field_indicator,
    second_field_indicator, alternate_field_indicator}) |->
    ($past(psel && penable && pwrite) || $past(psel && penable && pwrite, 2) ||
    !$past(presetn) || !$past(presetn, 2)))
    else $error("field indicator changed without a write");
  a_slverr_in_access: assert property (pslverr |-> s_apb_access)
    else $error("slave error outside access phase");
  a_ready_in_access: assert property (s_apb_access |-> pready)
    else $error("ready low in access phase");
endmodule // vlft_checker

bind vlft_top vlft_checker vlft_checker_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pready(pready), .pslverr(pslverr), .line_sync(line_sync),
  .holdoff_done(holdoff_done), .trig_fire(trig_fire),
  .first_field_indicator(first_field_indicator),
  .second_field_indicator(second_field_indicator),
  .alternate_field_indicator(alternate_field_indicator),
  .any_line_indicator(any_line_indicator), .line_readout_show(line_readout_show),
  .level_readout_show(level_readout_show), .clamp_ch2_en(clamp_ch2_en),
  .clamp_msg(clamp_msg)
);
`default_nettype wire

// >>> dv/vlft_sync_model.sv
// Behavioural sync separator driving line and field sync pulses.
// Assumes pclk from the bench; both pins idle low between pulses.
`default_nettype none
module vlft_sync_model (
  // Clock
  input wire logic pclk,
  // Sync pins
  output logic line_sync,
  output logic field_sync
);
  timeunit 1ns;
  timeprecision 1ns;
  // Pins idle low
  initial begin
    line_sync = 1'b0;
    field_sync = 1'b0;
  end
  // Field start, long gap after the last line means field one
  task automatic field(input bit f1);
    repeat (f1 ? 2400 : 40) @(posedge pclk);
    field_sync <= 1'b1;
    repeat (4) @(posedge pclk);
    field_sync <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask
  // Line pulses, four cycles high then low
  task automatic lines(input int n);
    repeat (n) begin
      @(posedge pclk);
      line_sync <= 1'b1;
      repeat (4) @(posedge pclk);
      line_sync <= 1'b0;
      repeat (3) @(posedge pclk);
    end
  endtask
endmodule // vlft_sync_model
`default_nettype wire

// >>> dv/testbench.sv
// Self-checking bench for the video line and field trigger selector.
// Assumes APB tasks drive the bus and the sync model drives the sync pins.
`default_nettype none
module testbench;
  import vlft_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, psel, penable, pwrite, holdoff_done;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic pready, pslverr, rerr, line_sync, field_sync, trig_fire;
  logic [15:0] sweep_delay;
  logic ffi, sfi, afi, ali, lrs, lvs, cen, cmsg;
  int fails, n_tests, fires, f0;
  vlft_top vlft_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .line_sync(line_sync), .field_sync(field_sync),
    .holdoff_done(holdoff_done), .trig_fire(trig_fire), .sweep_delay(sweep_delay),
    .first_field_indicator(ffi), .second_field_indicator(sfi),
    .alternate_field_indicator(afi), .any_line_indicator(ali), .line_readout_show(lrs),
    .level_readout_show(lvs), .clamp_ch2_en(cen), .clamp_msg(cmsg));
  vlft_sync_model vlft_sync_model_i (.pclk(pclk), .line_sync(line_sync),
    .field_sync(field_sync));
  // Clock
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // Trigger pulse counter
  always @(posedge pclk) if (trig_fire === 1'b1) fires <= fires + 1;
  // ****************************************
  // Tasks
  // ****************************************
  task automatic end_sim;
    if (fails == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      fails++;
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      fails++;
      end_sim();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    // Let registered outputs settle after the write
    repeat (2) @(posedge pclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
    input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rdat & m);
  endtask
  task automatic burst(input bit f1, input int n, input int e, input string nm);
    f0 = fires;
    vlft_sync_model_i.field(f1);
    vlft_sync_model_i.lines(n);
    repeat (6) @(posedge pclk);
    chk(nm, 32'(e), 32'(fires - f0));
  endtask
  // Watchdog
  initial begin
    repeat (80000) @(posedge pclk);
    fails++;
    end_sim();
  end
  // Main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    holdoff_done = 1'b1;
    fails = 0;
    n_tests = 0;
    fires = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    rd(ADDR_CTRL, 32'h04, 32'hff, "ctrl_reset");
    rd(ADDR_LINE, 32'h1, 32'h3ff, "line_reset");
    rd(ADDR_BLEVEL, 32'h200, 32'h3ff, "blevel_reset");
    rd(ADDR_MAIN_DLY, 32'h0, 32'hffff, "main_reset");
    rd(ADDR_KNOB, 32'h0, 32'hffffffff, "knob_read");
    rd(8'h40, 32'h0, 32'hffffffff, "unmapped_data");
    chk("unmapped_err", 32'h1, {31'h0, rerr});
    chk("first_ind_reset", 32'h1, {31'h0, ffi});
    wr(ADDR_CTRL, 32'h11);
    rd(ADDR_CTRL, 32'h10, 32'hff, "ctrl_field2_refused");
    chk("clamp_on", 32'h3, {30'h0, cen, cmsg});
    wr(ADDR_CTRL, 32'h00);
    chk("clamp_off", 32'h0, {30'h0, cen, cmsg});
    wr(ADDR_KNOB, 32'h1);
    rd(ADDR_LINE, 32'h2, 32'h3ff, "knob_cw");
    wr(ADDR_KNOB, 32'h2);
    rd(ADDR_LINE, 32'h1, 32'h3ff, "knob_ccw");
    wr(ADDR_KNOB, 32'h3);
    rd(ADDR_LINE, 32'h1, 32'h3ff, "knob_both");
    wr(ADDR_LINE, 32'h3);
    burst(1'b1, 4, 1, "f1_fires_in_f1");
    burst(1'b0, 4, 0, "f1_quiet_in_f2");
    rd(ADDR_STATUS, 32'h1005, 32'h1bff, "status_f2");
    wr(ADDR_LINE, 32'h1);
    wr(ADDR_KNOB, 32'h2);
    rd(ADDR_LINE, 32'd262, 32'h3ff, "wrap_down_line");
    rd(ADDR_CTRL, 32'h1, 32'h3, "wrap_down_mode");
    chk("wrap_down_ind", 32'h1, {31'h0, sfi});
    wr(ADDR_LINE, 32'd262);
    wr(ADDR_KNOB, 32'h1);
    rd(ADDR_LINE, 32'h1, 32'h3ff, "wrap_up_line");
    rd(ADDR_CTRL, 32'h0, 32'h3, "wrap_up_mode");
    wr(ADDR_CTRL, 32'h01);
    wr(ADDR_LINE, 32'h3);
    burst(1'b1, 4, 0, "f2_quiet_in_f1");
    burst(1'b0, 4, 1, "f2_fires_in_f2");
    wr(ADDR_MAIN_DLY, 32'h10);
    wr(ADDR_DELTA_DLY, 32'h5);
    wr(ADDR_CTRL, 32'hc2);
    burst(1'b1, 4, 1, "alt_f1");
    chk("delay_f1", 32'h10, {16'h0, sweep_delay});
    burst(1'b0, 4, 1, "alt_f2");
    chk("delay_f2", 32'h15, {16'h0, sweep_delay});
    chk("alt_ind", 32'h1, {31'h0, afi});
    wr(ADDR_LINE, 32'd262);
    wr(ADDR_KNOB, 32'h1);
    rd(ADDR_LINE, 32'h1, 32'h3ff, "alt_wrap_up");
    wr(ADDR_KNOB, 32'h2);
    rd(ADDR_LINE, 32'd262, 32'h3ff, "alt_wrap_down");
    rd(ADDR_CTRL, 32'hc2, 32'hff, "alt_mode_kept");
    wr(ADDR_CTRL, 32'h04);
    wr(ADDR_LINE, 32'h6);
    burst(1'b1, 4, 1, "sysm_fire");
    rd(ADDR_STATUS, 32'h1808, 32'h1bff, "status_sysm");
    wr(ADDR_CTRL, 32'h07);
    chk("any_ind", 32'h2, {30'h0, ali, lrs});
    holdoff_done <= 1'b0;
    burst(1'b0, 2, 0, "any_holdoff");
    holdoff_done <= 1'b1;
    burst(1'b1, 2, 2, "any_lines");
    wr(ADDR_CTRL, 32'h24);
    wr(ADDR_KNOB, 32'h1);
    rd(ADDR_BLEVEL, 32'h201, 32'h3ff, "blevel_knob");
    rd(ADDR_LINE, 32'h6, 32'h3ff, "line_kept");
    end_sim();
  end
endmodule // testbench
`default_nettype wire
